/* File: include/dhif_pkg.sv */
// Shared constants and state types for the display host interface front end.
package dhif_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int CORE_CLK_HZ = 20_000_000;
   localparam int CORE_CLK_MHZ = CORE_CLK_HZ / 1_000_000;
   // Select must stay high this long before the bit counter restarts.
   localparam int SPI_RESYNC_NS = 55000;
   localparam int SPI_RESYNC_CYC = (SPI_RESYNC_NS * CORE_CLK_MHZ + 999) / 1000;
   localparam int UART_BAUD = 115200;
   localparam int UART_BIT_CYC = CORE_CLK_HZ / UART_BAUD;
   localparam int UART_HALF_CYC = UART_BIT_CYC / 2;

   // ****************************************************************
   // Receive buffer
   // ****************************************************************
   localparam int BUF_DEPTH = 64;
   localparam int BUF_AW = 6;
   localparam logic [6:0] BUF_FULL_LEVEL = 7'h40;
   localparam logic [6:0] BUSY_LEVEL = 7'h20;
   localparam logic [2:0] LAST_BIT = 3'h7;

   // ****************************************************************
   // Interface selection codes
   // ****************************************************************
   localparam logic [2:0] MODE_FULL_SWING = 3'h0;
   localparam logic [2:0] MODE_LOGIC = 3'h1;
   localparam logic [2:0] MODE_LOGIC_INV = 3'h2;
   localparam logic [2:0] MODE_I2C = 3'h3;
   localparam logic [2:0] MODE_SPI = 3'h4;

   // Two-wire slave address after reset, decimal 42.
   localparam logic [6:0] I2C_DEFAULT_ADDR = 7'h2a;

   // ****************************************************************
   // State types
   // ****************************************************************
   typedef enum logic [1:0] {U_IDLE, U_START, U_DATA, U_STOP} dhif_uart_st_t;
   typedef enum logic [2:0] {
      I_IDLE, I_ADDR, I_AWAIT, I_AACK, I_WDATA, I_DWAIT, I_DACK, I_IGNORE
   } dhif_i2c_st_t;

endpackage : dhif_pkg

/* File: logic/dhif_frontend.sv */
// Receive front end: serial, two-wire and clocked serial slaves feeding a 64-byte buffer.
`timescale 1ns/100ps

module dhif_frontend
   import dhif_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [2:0] mode_sel,
   input wire logic [6:0] i2c_addr_in,
   input wire logic i2c_addr_load,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   input wire logic i2c_scl_in,
   input wire logic i2c_sda_in,
   output logic i2c_sda_out,
   output logic i2c_sda_oe,
   input wire logic serial_rx,
   input wire logic cmd_pop,
   output logic [7:0] cmd_data,
   output logic cmd_valid,
   output logic [6:0] buf_fill,
   output logic byte_dropped,
   output logic spi_label_on
);

   // ****************************************************************
   // Clocked serial link, serial clock domain
   // ****************************************************************
   logic [7:0] spi_sh_r;
   logic [2:0] spi_bit_r;
   logic [7:0] spi_byte_r;
   logic spi_tgl_r;
   logic spi_resync_r;
   logic spi_tgl_clr_r;
   wire spi_clr = spi_resync_r & spi_cs_n;

   // restart bit counter
   // The clear releases on the select pin itself, so the first clock after select
   // falls is never lost to synchroniser delay.
   // falling-edge sampling (mode 2 with the clock idling high), MSB first
   always_ff @(negedge spi_sclk or posedge spi_clr) begin
      if (spi_clr) begin
         spi_sh_r <= 8'h00;
         spi_bit_r <= 3'h0;
      end else if (!spi_cs_n) begin
         spi_sh_r <= {spi_sh_r[6:0], spi_mosi};
         spi_bit_r <= spi_bit_r + 3'h1;
      end
   end

   // The toggle is cleared only by core reset, together with its synchroniser, so a
   // select restart can never look like a new byte to the core side.
   always_ff @(negedge spi_sclk) begin
      if (!spi_cs_n && spi_bit_r == LAST_BIT) begin
         spi_byte_r <= {spi_sh_r[6:0], spi_mosi};
      end
   end

   always_ff @(negedge spi_sclk or posedge spi_tgl_clr_r) begin
      if (spi_tgl_clr_r) begin
         spi_tgl_r <= 1'b0;
      end else if (!spi_cs_n && spi_bit_r == LAST_BIT) begin
         spi_tgl_r <= ~spi_tgl_r;
      end
   end

   // ****************************************************************
   // Clocked serial link, core side
   // ****************************************************************
   logic cs_s1_r, cs_s2_r;
   logic tgl_s1_r, tgl_s2_r, tgl_seen_r;
   logic [10:0] cs_cnt_r;
   logic [6:0] fill;
   logic spi_mode;
   assign spi_mode = (mode_sel == MODE_SPI);
   wire spi_new = (tgl_s2_r != tgl_seen_r);
   wire spi_push = spi_mode && spi_new;
   wire cs_cnt_done = (cs_cnt_r == 11'(SPI_RESYNC_CYC - 1));

   always_ff @(posedge core_clk) begin
      cs_s1_r <= spi_cs_n;
      cs_s2_r <= cs_s1_r;
      spi_tgl_clr_r <= !rstn;
      if (!rstn) begin
         tgl_s1_r <= 1'b0;
         tgl_s2_r <= 1'b0;
         tgl_seen_r <= 1'b0;
      end else begin
         tgl_s1_r <= spi_tgl_r;
         tgl_s2_r <= tgl_s1_r;
         tgl_seen_r <= tgl_s2_r;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         cs_cnt_r <= 11'h000;
         spi_resync_r <= 1'b1;
      end else if (!cs_s2_r) begin
         cs_cnt_r <= 11'h000;
         spi_resync_r <= 1'b0;
      end else if (cs_cnt_done) begin
         spi_resync_r <= 1'b1;
      end else begin
         cs_cnt_r <= cs_cnt_r + 11'h001;
      end
   end

   // ****************************************************************
   // Asynchronous serial receiver
   // ****************************************************************
   logic rx_s1_r, rx_s2_r;
   dhif_uart_st_t u_st_r;
   logic [7:0] u_cnt_r;
   logic [2:0] u_bit_r;
   logic [7:0] u_sh_r;
   logic uart_mode;
   assign uart_mode = (mode_sel == MODE_FULL_SWING) || (mode_sel == MODE_LOGIC) ||
                      (mode_sel == MODE_LOGIC_INV);
   wire rx_bit = rx_s2_r ^ (mode_sel == MODE_LOGIC_INV);
   wire u_tick = (u_cnt_r == 8'h00);
   wire uart_push = uart_mode && (u_st_r == U_STOP) && u_tick && rx_bit;

   always_ff @(posedge core_clk) begin
      rx_s1_r <= serial_rx;
      rx_s2_r <= rx_s1_r;
   end

   always_ff @(posedge core_clk) begin
      if (!rstn || !uart_mode) begin
         u_st_r <= U_IDLE;
         u_cnt_r <= 8'h00;
         u_bit_r <= 3'h0;
         u_sh_r <= 8'h00;
      end else begin
         u_cnt_r <= u_tick ? 8'(UART_BIT_CYC - 1) : u_cnt_r - 8'h01;
         case (u_st_r)
            U_IDLE: begin
               u_cnt_r <= 8'(UART_HALF_CYC - 1);
               if (!rx_bit) begin
                  u_st_r <= U_START;
               end
            end
            U_START: begin
               if (u_tick) begin
                  u_bit_r <= 3'h0;
                  u_st_r <= rx_bit ? U_IDLE : U_DATA;
               end
            end
            U_DATA: begin
               if (u_tick) begin
                  u_sh_r <= {rx_bit, u_sh_r[7:1]};
                  u_bit_r <= u_bit_r + 3'h1;
                  if (u_bit_r == LAST_BIT) begin
                     u_st_r <= U_STOP;
                  end
               end
            end
            default: begin
               if (u_tick) begin
                  u_st_r <= U_IDLE;
               end
            end
         endcase
      end
   end

   // ****************************************************************
   // Two-wire slave
   // ****************************************************************
   logic scl_s1_r, scl_s2_r, scl_s3_r;
   logic sda_s1_r, sda_s2_r, sda_s3_r;
   logic [6:0] i2c_addr_r;
   dhif_i2c_st_t i_st_r;
   logic [7:0] i_sh_r;
   logic [2:0] i_bit_r;
   logic i2c_sda_oe_r;
   logic i2c_mode;
   assign i2c_mode = (mode_sel == MODE_I2C);
   wire scl_rise = scl_s2_r & ~scl_s3_r;
   wire scl_fall = ~scl_s2_r & scl_s3_r;
   wire i_start = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
   wire i_stop = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;
   wire [7:0] i_byte = {i_sh_r[6:0], sda_s2_r};
   wire i_match = (i_sh_r[7:1] == i2c_addr_r);
   wire i2c_push = i2c_mode && (i_st_r == I_WDATA) && scl_rise && (i_bit_r == LAST_BIT);

   always_ff @(posedge core_clk) begin
      scl_s1_r <= i2c_scl_in;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      sda_s1_r <= i2c_sda_in;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         i2c_addr_r <= I2C_DEFAULT_ADDR;
      end else if (i2c_addr_load) begin
         i2c_addr_r <= i2c_addr_in;
      end
   end

   // slave only
   // A read is acknowledged and then left alone, so the master clocks in all ones.
   always_ff @(posedge core_clk) begin
      if (!rstn || !i2c_mode || i_stop) begin
         i_st_r <= I_IDLE;
         i_sh_r <= 8'h00;
         i_bit_r <= 3'h0;
         i2c_sda_oe_r <= 1'b0;
      end else if (i_start) begin
         i_st_r <= I_ADDR;
         i_bit_r <= 3'h0;
         i2c_sda_oe_r <= 1'b0;
      end else begin
         if (scl_rise && (i_st_r == I_ADDR || i_st_r == I_WDATA)) begin
            i_sh_r <= i_byte;
            i_bit_r <= i_bit_r + 3'h1;
         end
         case (i_st_r)
            I_ADDR: begin
               if (scl_rise && i_bit_r == LAST_BIT) begin
                  i_st_r <= I_AWAIT;
               end
            end
            I_AWAIT: begin
               if (scl_fall) begin
                  i2c_sda_oe_r <= i_match;
                  i_st_r <= i_match ? I_AACK : I_IGNORE;
               end
            end
            I_AACK: begin
               if (scl_fall) begin
                  i2c_sda_oe_r <= 1'b0;
                  i_bit_r <= 3'h0;
                  i_st_r <= i_sh_r[0] ? I_IGNORE : I_WDATA;
               end
            end
            I_WDATA: begin
               if (scl_rise && i_bit_r == LAST_BIT) begin
                  i_st_r <= I_DWAIT;
               end
            end
            I_DWAIT: begin
               if (scl_fall) begin
                  i2c_sda_oe_r <= 1'b1;
                  i_st_r <= I_DACK;
               end
            end
            I_DACK: begin
               if (scl_fall) begin
                  i2c_sda_oe_r <= 1'b0;
                  i_bit_r <= 3'h0;
                  i_st_r <= I_WDATA;
               end
            end
            default: begin
               i2c_sda_oe_r <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************************************
   // Shared receive buffer
   // ****************************************************************
   logic [7:0] mem [0:BUF_DEPTH-1];
   logic [BUF_AW:0] wr_ptr_r, rd_ptr_r;
   logic [7:0] cmd_data_r;
   logic cmd_valid_r, drop_r;
   logic [6:0] fill_r;
   logic spi_miso_r, spi_label_r, sda_out_r;
   wire push = spi_push || uart_push || i2c_push;
   wire [7:0] push_data = spi_push ? spi_byte_r : (uart_push ? u_sh_r : i_byte);
   wire [6:0] mem_level = wr_ptr_r - rd_ptr_r;
   wire take = cmd_valid_r && cmd_pop;
   // capacity counts the output register too
   assign fill = mem_level + {6'h00, cmd_valid_r};
   wire full = (fill == BUF_FULL_LEVEL);
   wire wr_en = push && !full;
   wire load = (!cmd_valid_r || cmd_pop) && (mem_level != 7'h00);

   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_ptr_r[BUF_AW-1:0]] <= push_data;
      end
      if (load) begin
         cmd_data_r <= mem[rd_ptr_r[BUF_AW-1:0]];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         wr_ptr_r <= 7'h00;
         rd_ptr_r <= 7'h00;
         cmd_valid_r <= 1'b0;
         drop_r <= 1'b0;
         fill_r <= 7'h00;
      end else begin
         wr_ptr_r <= wr_ptr_r + {6'h00, wr_en};
         rd_ptr_r <= rd_ptr_r + {6'h00, load};
         cmd_valid_r <= load || (cmd_valid_r && !take);
         drop_r <= push && full;
         fill_r <= fill;
      end
   end

   // ****************************************************************
   // Status outputs
   // ****************************************************************
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         spi_miso_r <= 1'b0;
         spi_label_r <= 1'b0;
         sda_out_r <= 1'b0;
      end else begin
         spi_miso_r <= spi_mode && (fill >= BUSY_LEVEL);
         spi_label_r <= spi_mode;
         sda_out_r <= 1'b0;
      end
   end

   assign spi_miso = spi_miso_r;
   assign i2c_sda_out = sda_out_r;
   assign i2c_sda_oe = i2c_sda_oe_r;
   assign cmd_data = cmd_data_r;
   assign cmd_valid = cmd_valid_r;
   assign buf_fill = fill_r;
   assign byte_dropped = drop_r;
   assign spi_label_on = spi_label_r;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sequence s_push_empty;
      push && (fill == 7'h00);
   endsequence
   sequence s_word_out;
      ##1 cmd_valid_r && (cmd_data_r == $past(push_data, 2));
   endsequence

   property p_busy_set;
      spi_mode && (fill >= BUSY_LEVEL) |=> spi_miso;
   endproperty
   a_busy_set: assert property (p_busy_set) else $error("busy line not raised");
   property p_busy_clr;
      (fill < BUSY_LEVEL) |=> !spi_miso;
   endproperty
   a_busy_clr: assert property (p_busy_clr) else $error("busy line not released");
   property p_cap;
      fill <= BUF_FULL_LEVEL;
   endproperty
   a_cap: assert property (p_cap) else $error("buffer over capacity");
   property p_drop;
      push && full && !load |=> byte_dropped && (fill == BUF_FULL_LEVEL) && $stable(wr_ptr_r);
   endproperty
   a_drop: assert property (p_drop) else $error("full buffer was disturbed");
   property p_order;
      s_push_empty |=> s_word_out;
   endproperty
   a_order: assert property (p_order) else $error("byte not delivered in order");
   property p_resync;
      cs_s2_r && cs_cnt_done |=> spi_resync_r && (!spi_cs_n || spi_bit_r == 3'h0);
   endproperty
   a_resync: assert property (p_resync) else $error("bit counter not restarted");
   property p_spi_only;
      !spi_mode && !uart_push && !i2c_push |=> $stable(wr_ptr_r);
   endproperty
   a_spi_only: assert property (p_spi_only) else $error("spi byte taken in other mode");
   property p_i2c_ack;
      (i_st_r == I_AWAIT) && scl_fall && i_match && !i_start && !i_stop && i2c_mode
         |=> i2c_sda_oe && (i_st_r == I_AACK);
   endproperty
   a_i2c_ack: assert property (p_i2c_ack) else $error("own address not acknowledged");
   property p_i2c_nack;
      (i_st_r == I_AWAIT) && scl_fall && !i_match |=> !i2c_sda_oe;
   endproperty
   a_i2c_nack: assert property (p_i2c_nack) else $error("foreign address acknowledged");
   property p_label;
      spi_mode ##1 spi_mode |-> spi_label_on;
   endproperty
   a_label: assert property (p_label) else $error("serial label not shown");

endmodule : dhif_frontend

/* File: tb/dhif_frontend_tb.sv */
// Self-checking bench for the receive front end.
`timescale 1ns/100ps
module dhif_frontend_tb
   import dhif_pkg::*;
;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [2:0] mode_sel = MODE_SPI;
   logic [6:0] i2c_addr_in = 7'h00;
   logic i2c_addr_load = 1'b0;
   logic cmd_pop = 1'b0;
   logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, i2c_scl, sda_drv, sda_wire, serial_rx;
   logic i2c_sda_out, i2c_sda_oe, cmd_valid, byte_dropped, spi_label_on, ack;
   logic [7:0] cmd_data;
   logic [6:0] buf_fill;
   logic [2:0] umode [3] = '{MODE_FULL_SWING, MODE_LOGIC, MODE_LOGIC_INV};
   int num_errors = 0;
   int checks = 0;
   int drops = 0;

   always #25 core_clk = ~core_clk;
   // Pulled-up data line; either party may pull it low.
   assign sda_wire = sda_drv & ~(i2c_sda_oe & ~i2c_sda_out);

   dhif_frontend dhif_frontend_inst (.core_clk(core_clk), .rstn(rstn), .mode_sel(mode_sel),
      .i2c_addr_in(i2c_addr_in), .i2c_addr_load(i2c_addr_load), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .i2c_scl_in(i2c_scl),
      .i2c_sda_in(sda_wire), .i2c_sda_out(i2c_sda_out), .i2c_sda_oe(i2c_sda_oe),
      .serial_rx(serial_rx), .cmd_pop(cmd_pop), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
      .buf_fill(buf_fill), .byte_dropped(byte_dropped), .spi_label_on(spi_label_on));

   dhif_host_model dhif_host_model_inst (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .i2c_scl(i2c_scl), .i2c_sda_drv(sda_drv), .i2c_sda(sda_wire),
      .serial_rx(serial_rx));

   always @(posedge core_clk) begin
      if (byte_dropped === 1'b1) begin
         drops++;
      end
   end

   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic settle(input int n);
      repeat (n) @(negedge core_clk);
   endtask : settle

   task automatic pop_check(input logic [7:0] exp);
      int n;
      n = 0;
      while (cmd_valid !== 1'b1 && n < 400) begin
         @(negedge core_clk);
         n++;
      end
      check("cmd_valid", 8'h01, {7'h00, cmd_valid});
      check("cmd_data", exp, cmd_data);
      cmd_pop = 1'b1;
      settle(1);
      cmd_pop = 1'b0;
      settle(1);
   endtask : pop_check

   task automatic i2c_write(input logic [7:0] addr, input logic [7:0] data, input logic line);
      dhif_host_model_inst.i2c_start();
      dhif_host_model_inst.i2c_byte(addr, ack);
      check("addr_ack_line", {7'h00, line}, {7'h00, ack});
      dhif_host_model_inst.i2c_byte(data, ack);
      dhif_host_model_inst.i2c_stop();
      settle(10);
   endtask : i2c_write

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up

   initial begin
      #3000000;
      num_errors++;
      $display("BAD watchdog expected finish seen timeout");
      wrap_up();
   end

   initial begin
      settle(3);
      rstn = 1'b1;
      settle(3);
      check("buf_fill", 8'h00, {1'b0, buf_fill});
      check("spi_label_on", 8'h01, {7'h00, spi_label_on});
      dhif_host_model_inst.spi_xfer(8'hff, 8, 1'b0);
      dhif_host_model_inst.spi_xfer(8'hf0, 4, 1'b1);
      #60000;
      check("spi_miso", 8'h00, {7'h00, spi_miso});
      dhif_host_model_inst.spi_xfer(8'ha5, 8, 1'b1);
      dhif_host_model_inst.spi_xfer(8'h3c, 8, 1'b1);
      settle(10);
      check("buf_fill", 8'h02, {1'b0, buf_fill});
      pop_check(8'ha5);
      pop_check(8'h3c);
      $display("test spi_basic done");
      for (int i = 0; i < 65; i++) begin
         dhif_host_model_inst.spi_xfer(8'(i * 3), 8, 1'b1);
         if (i == 30 || i == 31) begin
            settle(10);
            check("spi_miso", {7'h00, i == 31}, {7'h00, spi_miso});
         end
      end
      settle(10);
      check("buf_fill", 8'h40, {1'b0, buf_fill});
      check("drops", 8'h01, 8'(drops));
      for (int i = 0; i < 64; i++) begin
         pop_check(8'(i * 3));
         if (i == 31 || i == 32) begin
            settle(3);
            check("spi_miso", {7'h00, i == 31}, {7'h00, spi_miso});
         end
      end
      $display("test spi_fill done");
      mode_sel = MODE_I2C;
      settle(4);
      check("spi_label_on", 8'h00, {7'h00, spi_label_on});
      i2c_write(8'h54, 8'h37, 1'b0);
      i2c_write(8'h56, 8'h11, 1'b1);
      i2c_write(8'h55, 8'h77, 1'b0);
      pop_check(8'h37);
      i2c_addr_in = 7'h15;
      i2c_addr_load = 1'b1;
      settle(1);
      i2c_addr_load = 1'b0;
      i2c_write(8'h54, 8'h22, 1'b1);
      i2c_write(8'h2a, 8'h5e, 1'b0);
      check("buf_fill", 8'h01, {1'b0, buf_fill});
      pop_check(8'h5e);
      $display("test two_wire done");
      for (int m = 0; m < 3; m++) begin
         dhif_host_model_inst.set_idle(umode[m] == MODE_LOGIC_INV);
         mode_sel = umode[m];
         settle(200);
         dhif_host_model_inst.spi_xfer(8'h99, 8, 1'b1);
         dhif_host_model_inst.uart_byte(8'h4b + 8'(m), umode[m] == MODE_LOGIC_INV);
         pop_check(8'h4b + 8'(m));
      end
      $display("test async_serial done");
      wrap_up();
   end
endmodule : dhif_frontend_tb

/* File: tb/dhif_host_model.sv */
// Host model that drives the clocked serial, two-wire and async serial pins.
`timescale 1ns/100ps
module dhif_host_model
   import dhif_pkg::*;
(
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   output logic i2c_scl,
   output logic i2c_sda_drv,
   input wire logic i2c_sda,
   output logic serial_rx
);
   // Clock held at 8 MHz, the fastest the host may run.
   localparam real SPI_HALF_NS = 62.5;
   localparam int I2C_HALF_NS = 1250;
   localparam int UART_BIT_NS = UART_BIT_CYC * 50;

   initial begin
      spi_sclk = 1'b1;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
      i2c_scl = 1'b1;
      i2c_sda_drv = 1'b1;
      serial_rx = 1'b1;
   end

   // ****************************************************************
   // Clocked serial
   // ****************************************************************
   // Mode 2 (clock idles high, data sampled on the falling edge), MSB first, select held.
   task automatic spi_xfer(input logic [7:0] data, input int nbits, input logic sel);
      spi_cs_n = ~sel;
      #(SPI_HALF_NS);
      for (int i = 7; i > 7 - nbits; i--) begin
         spi_mosi = data[i];
         #(SPI_HALF_NS);
         spi_sclk = 1'b0;
         #(SPI_HALF_NS);
         spi_sclk = 1'b1;
      end
      #(SPI_HALF_NS);
      spi_cs_n = 1'b1;
      // A released data line must not keep showing the last bit.
      spi_mosi = ~spi_mosi;
   endtask : spi_xfer

   // ****************************************************************
   // Two-wire master
   // ****************************************************************
   task automatic i2c_start();
      i2c_sda_drv = 1'b0;
      #(I2C_HALF_NS);
      i2c_scl = 1'b0;
   endtask : i2c_start

   // One byte, MSB first, then the line released for a ninth clock that samples the ack bit.
   task automatic i2c_byte(input logic [7:0] data, output logic ack);
      logic [8:0] sh;
      sh = {data, 1'b1};
      for (int i = 0; i < 9; i++) begin
         #(I2C_HALF_NS / 2);
         i2c_sda_drv = sh[8];
         sh = sh << 1;
         #(I2C_HALF_NS / 2);
         i2c_scl = 1'b1;
         #(I2C_HALF_NS);
         ack = i2c_sda;
         i2c_scl = 1'b0;
      end
   endtask : i2c_byte

   task automatic i2c_stop();
      #(I2C_HALF_NS / 2);
      i2c_sda_drv = 1'b0;
      #(I2C_HALF_NS / 2);
      i2c_scl = 1'b1;
      #(I2C_HALF_NS);
      i2c_sda_drv = 1'b1;
      #(I2C_HALF_NS);
   endtask : i2c_stop

   // ****************************************************************
   // Async serial transmitter
   // ****************************************************************
   task automatic set_idle(input logic inv);
      serial_rx = ~inv;
   endtask : set_idle

   task automatic uart_byte(input logic [7:0] data, input logic inv);
      logic [9:0] frame;
      frame = {1'b1, data, 1'b0};
      for (int i = 0; i < 10; i++) begin
         serial_rx = frame[i] ^ inv;
         #(UART_BIT_NS);
      end
   endtask : uart_byte
endmodule : dhif_host_model
